// [verilog/rllc_codec.sv]
`timescale 1ns/100ps
`include "rllc_params.svh"

// Operation
// - Decode each framed three-bit code word to a two-bit data word by lookup.
// - Code word boundaries on the decode path follow the repeating 001 pattern.
// - After encoder enable and a settling delay, capture write data on write clock rises.
// - Drain the write FIFO on the block clock, one data word per three cycles.
// - Odd framing pairs bits seven-six, five-four, three-two, one-zero.
// - Even framing pairs six-five, four-three, two-one, and zero with next seven.
// - Framing chosen at encoder enable comes from the encode framing select.
// - After an address mark, framing comes from the mark framing select.
// - After the address mark, encoding and serial output resume.
// - After a mark, framing is fixed only at the first one on write data.
// - The decode word is previous two, current three and next two code bits.
// - Adjacent ones force the fill pattern and set the decode error flag.
// - The decoder starts only after 001001001 is seen following phase lock.
// - Each code word comes from current word, next word and previous last bit.
module rllc_codec #(
  parameter int FIFO_DEPTH_LOG2 = `RLLC_FIFO_DEPTH_LOG2,
  parameter logic [3:0] SYNC_DELAY = `RLLC_ENC_SYNC_DELAY
) (
  input wire logic clk, // Channel-rate clock, 10 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic write_clk, // Controller write clock pin.
  input wire logic write_data, // Controller serial write data pin.
  input wire logic encoder_enable, // Encoder enable pin, active high.
  input wire logic mark_generate_enable, // Address mark generation in progress.
  input wire logic encode_odd_framing_n, // Low selects odd framing at encoder enable.
  input wire logic mark_odd_framing_n, // Low selects odd framing after a mark.
  output logic precomp_write_out, // Serial coded write stream.
  output logic write_overrun, // Write FIFO overflowed since enable.
  input wire logic code_bit, // Synchronized code bit.
  input wire logic code_bit_valid, // Qualifies code_bit.
  input wire logic phase_lock, // High once the synchronizer is in phase lock.
  input wire logic error_fill_select, // Fill value for illegal decode words.
  input wire logic decode_error_clear, // Clears the decode error flag.
  output logic [1:0] nrz_word, // Decoded data word.
  output logic nrz_valid, // Pulse marking nrz_word.
  output logic decoder_active, // Decoder has framed and runs.
  output logic decode_error_flag // Sticky decode error.
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic wclk_s1_q, wclk_s2_q, wclk_s3_q;
  logic wdat_s1_q, wdat_s2_q;
  logic enc_s1_q, enc_s2_q, enc_on_q;
  logic mark_s1_q, mark_s2_q, mark_q;

  // Write clock and write data pins pass two flops, encoder enable and mark pins three; the third write clock flop only finds edges.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {wclk_s1_q, wclk_s2_q, wclk_s3_q} <= 3'h0;
      {wdat_s1_q, wdat_s2_q} <= 2'h0;
      {enc_s1_q, enc_s2_q, enc_on_q} <= 3'h0;
      {mark_s1_q, mark_s2_q, mark_q} <= 3'h0;
    end else begin
      {wclk_s1_q, wclk_s2_q, wclk_s3_q} <= {write_clk, wclk_s1_q, wclk_s2_q};
      {wdat_s1_q, wdat_s2_q} <= {write_data, wdat_s1_q};
      {enc_s1_q, enc_s2_q, enc_on_q} <= {encoder_enable, enc_s1_q, enc_s2_q};
      {mark_s1_q, mark_s2_q, mark_q} <= {mark_generate_enable, mark_s1_q, mark_s2_q};
    end
  end

  logic wclk_rise;
  logic enc_rise;
  logic mark_fall;
  logic enc_active;
  assign wclk_rise = wclk_s2_q && !wclk_s3_q;
  assign enc_rise = enc_s2_q && !enc_on_q;
  assign mark_fall = mark_q && !mark_s2_q;
  assign enc_active = enc_on_q && !mark_q;

  // --------------------------------------------------------------------------
  // Write capture and framing
  // --------------------------------------------------------------------------
  logic [3:0] dly_q;
  logic [2:0] bit_idx_q;
  logic frame_odd_q;
  logic mark_frame_q;
  logic awaiting_q;
  logic half_q;
  logic write_overrun_q;
  logic capture;
  logic [2:0] idx_w;
  logic frame_w;
  logic first_half;
  logic fifo_push;
  logic fifo_full;

  // Settling delay after enable hides the synchroniser and pin skew.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dly_q <= 4'h0;
    end else if (!enc_s2_q) begin
      dly_q <= 4'h0;
    end else if (dly_q != SYNC_DELAY) begin
      dly_q <= dly_q + 4'h1;
    end
  end

  // The mark fall cycle is excluded as well, so no stale bit index pushes a word there.
  assign capture = wclk_rise && enc_on_q && (dly_q == SYNC_DELAY) && !mark_s2_q && !mark_q;

  // At the first one after a mark the bit index is forced so this bit opens a pair.
  always_comb begin
    idx_w = bit_idx_q;
    frame_w = frame_odd_q;
    if (awaiting_q && wdat_s2_q) begin
      frame_w = mark_frame_q;
      idx_w = mark_frame_q ? `RLLC_ODD_FIRST_BIT : `RLLC_EVEN_FIRST_BIT;
    end
  end

  // A bit opens a pair when its byte index parity matches the framing.
  assign first_half = (idx_w[0] == frame_w);
  assign fifo_push = capture && !first_half;

  // Framing state: byte bit index, framing choice and the held first half.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_idx_q <= `RLLC_ODD_FIRST_BIT;
      frame_odd_q <= 1'b1;
      mark_frame_q <= 1'b1;
      awaiting_q <= 1'b0;
      half_q <= 1'b0;
    end else if (enc_rise) begin
      frame_odd_q <= !encode_odd_framing_n;
      bit_idx_q <= `RLLC_ODD_FIRST_BIT;
      awaiting_q <= 1'b0;
      half_q <= 1'b0; // Even framing pairs the first bit seven with a zero.
    end else if (mark_fall) begin
      mark_frame_q <= !mark_odd_framing_n;
      awaiting_q <= 1'b1;
      bit_idx_q <= `RLLC_ODD_FIRST_BIT;
      half_q <= 1'b0;
    end else if (capture) begin
      bit_idx_q <= idx_w - 3'h1;
      if (first_half) begin
        half_q <= wdat_s2_q;
      end
      if (awaiting_q && wdat_s2_q) begin
        awaiting_q <= 1'b0;
        frame_odd_q <= mark_frame_q;
      end
    end
  end

  // Overrun only flags; a word pushed into a full FIFO is lost.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_overrun_q <= 1'b0;
    end else if (fifo_push && fifo_full) begin
      write_overrun_q <= 1'b1;
    end else if (enc_rise) begin
      write_overrun_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Write FIFO and code word scheduling
  // --------------------------------------------------------------------------
  logic [1:0] fifo_rd_data;
  logic fifo_empty;
  logic rd_go;
  logic rd_pend_q;
  logic [1:0] cur_q, nxt_q;
  logic cur_v_q, nxt_v_q;
  logic r0_q;
  logic [1:0] rem_q;
  logic [1:0] sh_q;
  logic out_q;
  logic load_word;
  rllc_pkg::rllc_enc_in_type enc_in;
  logic [2:0] enc_w;

  rllc_fifo #(
    .WIDTH(`RLLC_WORD_BITS),
    .DEPTH_LOG2(FIFO_DEPTH_LOG2)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(!enc_s2_q),
    .wr_en(fifo_push),
    .wr_data({half_q, wdat_s2_q}),
    .rd_en(rd_go),
    .rd_data(fifo_rd_data),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  // One read in flight at most, so the lookahead word never overflows.
  assign rd_go = enc_active && !fifo_empty && !rd_pend_q && !nxt_v_q;
  assign load_word = enc_active && (rem_q == 2'h0) && cur_v_q && nxt_v_q;
  assign enc_in = '{cur: cur_q, nxt: nxt_q, r0: r0_q};
  assign enc_w = rllc_pkg::rllc_encode(enc_in);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= rd_go;
    end
  end

  // Current and lookahead data words; the lookahead is needed before encoding.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_q <= 2'h0;
      nxt_q <= 2'h0;
      cur_v_q <= 1'b0;
      nxt_v_q <= 1'b0;
    end else if (!enc_active) begin
      cur_v_q <= 1'b0;
      nxt_v_q <= 1'b0;
    end else if (load_word) begin
      cur_q <= nxt_q;
      nxt_q <= fifo_rd_data;
      nxt_v_q <= rd_pend_q;
    end else if (rd_pend_q) begin
      if (!cur_v_q) begin
        cur_q <= fifo_rd_data;
        cur_v_q <= 1'b1;
      end else begin
        nxt_q <= fifo_rd_data;
        nxt_v_q <= 1'b1;
      end
    end
  end

  // Serialiser; it idles low while starved, which the channel sees as no flux.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rem_q <= 2'h0;
      sh_q <= 2'h0;
      out_q <= 1'b0;
      r0_q <= 1'b0;
    end else if (!enc_active) begin
      rem_q <= 2'h0;
      sh_q <= 2'h0;
      out_q <= 1'b0;
      r0_q <= 1'b0;
    end else if (load_word) begin
      out_q <= enc_w[2];
      sh_q <= enc_w[1:0];
      rem_q <= `RLLC_CODE_REMAIN;
      r0_q <= enc_w[0];
    end else if (rem_q != 2'h0) begin
      out_q <= sh_q[1];
      sh_q <= {sh_q[0], 1'b0};
      rem_q <= rem_q - 2'h1;
    end else begin
      out_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Decoder framing and lookup
  // --------------------------------------------------------------------------
  rllc_pkg::rllc_hunt_type hunt_q;
  logic [8:0] sr_q;
  logic [8:0] sr_next;
  logic [1:0] phase_q;
  logic dec_fire;
  logic dec_adj;
  rllc_pkg::rllc_dec_word_type dec_win;
  logic [1:0] nrz_word_q;
  logic nrz_valid_q;
  logic decoder_active_q;
  logic decode_error_flag_q;

  assign sr_next = {sr_q[7:0], code_bit};
  assign dec_win = rllc_pkg::rllc_dec_word_type'(sr_next[6:0]);
  assign dec_fire = (hunt_q == rllc_pkg::hunt_decode) && code_bit_valid && (phase_q == `RLLC_DEC_PHASE_FIRE);
  assign dec_adj = rllc_pkg::rllc_has_adj(dec_win);

  // Code shift register; cleared while unlocked so stale bits never match.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sr_q <= 9'h000;
    end else if (hunt_q == rllc_pkg::hunt_idle) begin
      sr_q <= 9'h000;
    end else if (code_bit_valid) begin
      sr_q <= sr_next;
    end
  end

  // Hunt: leave idle on phase lock, frame on the sync pattern, then decode.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hunt_q <= rllc_pkg::hunt_idle;
      phase_q <= 2'h0;
      decoder_active_q <= 1'b0;
    end else if (!phase_lock) begin
      hunt_q <= rllc_pkg::hunt_idle;
      decoder_active_q <= 1'b0;
    end else begin
      case (hunt_q)
        rllc_pkg::hunt_idle: begin
          hunt_q <= rllc_pkg::hunt_search;
        end
        rllc_pkg::hunt_search: begin
          if (code_bit_valid && (sr_next == `RLLC_SYNC_PATTERN)) begin
            hunt_q <= rllc_pkg::hunt_decode;
            decoder_active_q <= 1'b1;
            phase_q <= 2'h0;
          end
        end
        rllc_pkg::hunt_decode: begin
          if (code_bit_valid) begin
            phase_q <= (phase_q == `RLLC_DEC_PHASE_LAST) ? 2'h0 : phase_q + 2'h1;
          end
        end
        default: begin
          hunt_q <= rllc_pkg::hunt_idle;
        end
      endcase
    end
  end

  // Lookup result, or the fill pattern for a word with adjacent ones.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nrz_word_q <= 2'h0;
      nrz_valid_q <= 1'b0;
    end else begin
      nrz_valid_q <= dec_fire;
      if (dec_fire) begin
        nrz_word_q <= dec_adj ? {2{error_fill_select}} : rllc_pkg::rllc_decode(dec_win);
      end
    end
  end

  // Sticky error; a new error in the clearing cycle wins.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      decode_error_flag_q <= 1'b0;
    end else if (dec_fire && dec_adj) begin
      decode_error_flag_q <= 1'b1;
    end else if (decode_error_clear) begin
      decode_error_flag_q <= 1'b0;
    end
  end

  assign precomp_write_out = out_q;
  assign write_overrun = write_overrun_q;
  assign nrz_word = nrz_word_q;
  assign nrz_valid = nrz_valid_q;
  assign decoder_active = decoder_active_q;
  assign decode_error_flag = decode_error_flag_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  decode_lookup_a: assert property (@(posedge clk) disable iff (sys_rst)
    dec_fire && !dec_adj |=> nrz_valid_q && (nrz_word_q == rllc_pkg::rllc_decode($past(dec_win))))
    else $error("Decoded word does not match lookup.");

  fill_pattern_a: assert property (@(posedge clk) disable iff (sys_rst)
    dec_fire && dec_adj |=> decode_error_flag_q && (nrz_word_q == {2{$past(error_fill_select)}}))
    else $error("Illegal decode word not filled or flagged.");

  sync_detect_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(decoder_active_q) |-> (sr_q == `RLLC_SYNC_PATTERN) && $past(phase_lock))
    else $error("Decoder started without sync pattern.");

  word_spacing_a: assert property (@(posedge clk) disable iff (sys_rst)
    load_word |=> !load_word ##1 !load_word)
    else $error("Code words closer than three cycles.");

  first_code_a: assert property (@(posedge clk) disable iff (sys_rst)
    load_word |=> precomp_write_out == $past(enc_w[2]))
    else $error("First code bit wrong.");

  last_code_a: assert property (@(posedge clk) disable iff (sys_rst)
    load_word ##1 enc_active ##1 enc_active |=> precomp_write_out == $past(enc_w[0], 3))
    else $error("Last code bit wrong.");

  enable_framing_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(enc_on_q) |-> frame_odd_q == !$past(encode_odd_framing_n))
    else $error("Framing not taken at encoder enable.");

  mark_framing_a: assert property (@(posedge clk) disable iff (sys_rst)
    awaiting_q && capture && wdat_s2_q && !enc_rise && !mark_fall |=> !awaiting_q && (frame_odd_q == $past(mark_frame_q)))
    else $error("Framing not forced at first one after mark.");

  capture_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    fifo_push |-> enc_on_q && (dly_q == SYNC_DELAY) && $past(wclk_s2_q) == 1'b0)
    else $error("Write data taken outside enable window.");

  mark_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    mark_q |=> !precomp_write_out)
    else $error("Output driven during address mark.");

endmodule // rllc_codec

// [verilog/rllc_params.svh]
`ifndef RLLC_PARAMS_SVH
`define RLLC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Decode path constants
// ----------------------------------------------------------------------------
`define RLLC_SYNC_PATTERN 9'h049
`define RLLC_DEC_PHASE_FIRE 2'h1
`define RLLC_DEC_PHASE_LAST 2'h2

// ----------------------------------------------------------------------------
// Encode path constants
// ----------------------------------------------------------------------------
`define RLLC_ENC_SYNC_DELAY 4'h4
`define RLLC_CODE_REMAIN 2'h2
`define RLLC_ODD_FIRST_BIT 3'h7
`define RLLC_EVEN_FIRST_BIT 3'h6
`define RLLC_FIFO_DEPTH_LOG2 4
`define RLLC_WORD_BITS 2

`endif

// [verilog/rllc_pkg.sv]
package rllc_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------

  // Seven bit decode word: two trailing bits of the previous code word, the
  // current code word and the two leading bits of the next one.
  typedef struct packed {
    logic [1:0] prev;
    logic [2:0] cur;
    logic [1:0] nxt;
  } rllc_dec_word_type;

  // Encoder inputs for one code word.
  typedef struct packed {
    logic [1:0] cur;
    logic [1:0] nxt;
    logic r0;
  } rllc_enc_in_type;

  typedef enum logic [1:0] {hunt_idle, hunt_search, hunt_decode} rllc_hunt_type;

  // --------------------------------------------------------------------------
  // Code functions
  // --------------------------------------------------------------------------

  // True when two adjacent ones appear anywhere in the decode word.
  function automatic logic rllc_has_adj(rllc_dec_word_type w);
    logic [6:0] b;
    b = w;
    return |(b[6:1] & b[5:0]);
  endfunction

  // Maps a legal decode word to its two-bit data word.
  function automatic logic [1:0] rllc_decode(rllc_dec_word_type w);
    logic [1:0] z;
    z = 2'h1;
    case ({w.prev, w.cur})
      5'h00, 5'h01, 5'h08: z = 2'h1;
      5'h02, 5'h12: z = (w.nxt == 2'h0) ? 2'h3 : 2'h2;
      5'h04, 5'h14: z = 2'h3;
      5'h05, 5'h15: z = 2'h2;
      5'h09, 5'h10, 5'h11: z = 2'h0;
      5'h0A: z = (w.nxt == 2'h0) ? 2'h1 : 2'h0;
      default: z = 2'h1;
    endcase
    return z;
  endfunction

  // Produces the three-bit code word for one data word.
  function automatic logic [2:0] rllc_encode(rllc_enc_in_type e);
    logic [2:0] r;
    r = 3'h0;
    case (e.cur)
      2'h0: r = e.nxt[1] ? (e.r0 ? 3'h2 : 3'h0) : 3'h1;
      2'h1: r = e.nxt[1] ? 3'h0 : (!e.r0 ? 3'h1 : (e.nxt[0] ? 3'h0 : 3'h2));
      2'h2: r = e.nxt[1] ? 3'h2 : 3'h5;
      default: r = (e.nxt == 2'h0) ? 3'h2 : 3'h4;
    endcase
    return r;
  endfunction

endpackage

// [verilog/rllc_fifo.sv]
`timescale 1ns/100ps

// Small synchronous FIFO; read data comes out of a register one cycle after
// the read strobe.
module rllc_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH_LOG2 = 4
) (
  input wire logic clk, // Block clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic flush, // Empties the FIFO.
  input wire logic wr_en, // Write strobe.
  input wire logic [WIDTH-1:0] wr_data, // Write word.
  input wire logic rd_en, // Read strobe.
  output logic [WIDTH-1:0] rd_data, // Registered read word.
  output logic empty, // No word stored.
  output logic full // No room left.
);

  logic [WIDTH-1:0] mem_q [0:(1<<DEPTH_LOG2)-1];
  logic [DEPTH_LOG2:0] wp_q;
  logic [DEPTH_LOG2:0] rp_q;

  assign empty = (wp_q == rp_q);
  assign full = (wp_q[DEPTH_LOG2] != rp_q[DEPTH_LOG2]) && (wp_q[DEPTH_LOG2-1:0] == rp_q[DEPTH_LOG2-1:0]);

  // Pointers carry one extra bit so that full and empty differ.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (wr_en && !full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (rd_en && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  // Storage has no reset; only pointers define what is valid.
  always_ff @(posedge clk) begin
    if (wr_en && !full) begin
      mem_q[wp_q[DEPTH_LOG2-1:0]] <= wr_data;
    end
  end

  // Read data is registered so the memory maps to block storage.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (rd_en && !empty) begin
      rd_data <= mem_q[rp_q[DEPTH_LOG2-1:0]];
    end
  end

endmodule // rllc_fifo

// [tb/rllc_ctrl_model.sv]
`timescale 1ns/100ps

// ------
// Controller model: sends a three-byte write frame MSB first on its own write clock.
// ------
module rllc_ctrl_model (
  input wire logic go, // Rising edge starts a frame.
  input wire logic [23:0] frame, // First byte in the top bits.
  output logic busy, // High while the frame goes out.
  output logic write_clk, // Write clock, still between frames.
  output logic write_data // Serial write data.
);
  initial begin
    busy = 1'b0;
    write_clk = 1'b0;
    write_data = 1'b0;
  end

  // Data moves only while the clock is low, so every rise sees a settled bit.
  // Frames open with a zero byte and put the first one on a bit of the chosen parity.
  // Between frames the controller holds write data low and leaves its write clock still.
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = 23; i >= 0; i--) begin
      write_data = frame[i];
      #400;
      write_clk = 1'b1;
      #400;
      write_clk = 1'b0;
    end
    write_data = 1'b0;
    busy = 1'b0;
  end
endmodule // rllc_ctrl_model

// [tb/test_rllc_codec.sv]
`timescale 1ns/100ps

// Bench: decode path from a code stream, encode path from the controller model.
module test_rllc_codec;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic write_clk, write_data, encoder_enable, mark_generate_enable, busy, go;
  logic encode_odd_framing_n, mark_odd_framing_n, precomp_write_out, write_overrun;
  logic code_bit, code_bit_valid, phase_lock, error_fill_select, decode_error_clear;
  logic nrz_valid, decoder_active, decode_error_flag;
  logic [1:0] nrz_word;
  logic [23:0] frame;
  logic [1:0] words_seen[$];
  logic [2:0] stream [7] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h4, 3'h0, 3'h6};
  logic [1:0] dexp [4];
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int ones = 0;

  rllc_codec #(.SYNC_DELAY(4'h4)) uut (.clk(clk), .sys_rst(sys_rst), .write_clk(write_clk),
    .write_data(write_data), .encoder_enable(encoder_enable), .mark_generate_enable(mark_generate_enable),
    .encode_odd_framing_n(encode_odd_framing_n), .mark_odd_framing_n(mark_odd_framing_n),
    .precomp_write_out(precomp_write_out), .write_overrun(write_overrun), .code_bit(code_bit),
    .code_bit_valid(code_bit_valid), .phase_lock(phase_lock), .error_fill_select(error_fill_select),
    .decode_error_clear(decode_error_clear), .nrz_word(nrz_word), .nrz_valid(nrz_valid),
    .decoder_active(decoder_active), .decode_error_flag(decode_error_flag));
  rllc_ctrl_model ctrl (.go(go), .frame(frame), .busy(busy), .write_clk(write_clk), .write_data(write_data));

  always #50 clk = ~clk;

  // Outputs are sampled mid-cycle, where they have settled; the ceiling cuts a hang short.
  always @(negedge clk) begin
    if (nrz_valid === 1'b1) words_seen.push_back(nrz_word);
    if (precomp_write_out === 1'b1) ones++;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ------
  // Compare and stimulus tasks
  // ------
  task automatic report(input string what);
    miscompares++;
    $display("CHECK FAILED at %0t: %s", $time, what);
  endtask
  task automatic check_flag(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) report(what);
  endtask
  task automatic check_word(input logic [1:0] got, input logic [1:0] exp, input string what);
    comparisons++;
    if (got !== exp) report(what);
  endtask
  task automatic check_count(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp) report(what);
  endtask
  // One code word, MSB first, one bit per cycle with no gaps.
  task automatic send_word(input logic [2:0] w);
    for (int i = 2; i >= 0; i--) begin
      @(negedge clk);
      code_bit = w[i];
      code_bit_valid = 1'b1;
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------
  // Test sequence
  // ------
  initial begin
    {encoder_enable, mark_generate_enable, encode_odd_framing_n, mark_odd_framing_n} = 4'h0;
    {code_bit, code_bit_valid, phase_lock, error_fill_select, decode_error_clear, go} = 6'h00;
    frame = 24'h000000;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check_word({decoder_active, decode_error_flag}, 2'h0, "reset state");
    check_flag(nrz_valid | precomp_write_out | write_overrun, 1'b0, "reset outputs");
    // Decode runs once per fill value; dropping lock between them sends the framer back to hunting.
    for (int f = 0; f < 2; f++) begin
      phase_lock = 1'b0;
      error_fill_select = f[0];
      dexp = '{2'h0, 2'h0, 2'h3, f[0] ? 2'h3 : 2'h0};
      @(negedge clk);
      check_flag(decoder_active, 1'b0, "active without lock");
      phase_lock = 1'b1;
      words_seen.delete();
      repeat (2) @(negedge clk);
      for (int k = 0; k < 7; k++) begin
        if (k == 2 || k == 4) check_flag(decoder_active, k == 4, "framing");
        send_word(stream[k]);
      end
      @(negedge clk);
      code_bit_valid = 1'b0;
      repeat (3) @(negedge clk);
      check_count(words_seen.size(), 4, "word count");
      for (int k = 0; k < 4; k++) check_word(words_seen[k], dexp[k], "decoded word");
      check_flag(decode_error_flag, 1'b1, "error flag");
      decode_error_clear = 1'b1;
      @(negedge clk);
      decode_error_clear = 1'b0;
      @(negedge clk);
      check_flag(decode_error_flag, 1'b0, "error clear");
    end
    // Encode: odd frame, even frame, then a mark that switches to even framing at the first one.
    for (int s = 0; s < 3; s++) begin
      encode_odd_framing_n = (s == 1);
      mark_odd_framing_n = (s == 2);
      frame = (s == 0) ? 24'h00AA00 : 24'h005500;
      ones = 0;
      encoder_enable = 1'b1;
      repeat (20) @(negedge clk);
      if (s == 2) begin
        mark_generate_enable = 1'b1;
        repeat (10) @(negedge clk);
        mark_generate_enable = 1'b0;
        repeat (10) @(negedge clk);
      end
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      for (int t = 0; t < 400 && busy === 1'b1; t++) @(negedge clk);
      repeat (80) @(negedge clk);
      check_count(ones, (s == 2) ? 11 : 12, "code ones");
      check_flag(write_overrun, 1'b0, "overrun");
      encoder_enable = 1'b0;
      repeat (10) @(negedge clk);
    end
    tally_and_finish();
  end
endmodule // test_rllc_codec
